// File: src/mdm_defines.svh
// Offsets, field positions, reset values and counts of the multiply/divide/accumulate unit
`ifndef MDM_DEFINES_SVH
`define MDM_DEFINES_SVH

`define MDM_OFS_A_LO 20'hFFFF0
`define MDM_OFS_A_HI 20'hFFFF2
`define MDM_OFS_B_LO 20'hFFFF4
`define MDM_OFS_B_HI 20'hFFFF6
`define MDM_OFS_C_LO 20'hF00E0
`define MDM_OFS_C_HI 20'hF00E2
`define MDM_OFS_CTRL 20'hF00E8
`define MDM_OFS_IST 20'hF00EA
`define MDM_OFS_IMASK 20'hF00EC

`define MDM_SEL_A_LO 0
`define MDM_SEL_A_HI 1
`define MDM_SEL_B_LO 2
`define MDM_SEL_B_HI 3
`define MDM_SEL_C_LO 4
`define MDM_SEL_C_HI 5
`define MDM_SEL_CTRL 6
`define MDM_SEL_IST 7
`define MDM_SEL_IMASK 8

`define MDM_CTRL_DIV 7
`define MDM_CTRL_MAC 6
`define MDM_CTRL_SGN 3
`define MDM_CTRL_OVF 2
`define MDM_CTRL_NEG 1
`define MDM_CTRL_GO 0

`define MDM_IST_MUL 0
`define MDM_IST_DIV 1
`define MDM_IST_OVF 2

`define MDM_DATA_RST 16'h0000
`define MDM_IRQ_RST 3'h0
`define MDM_DIV_LAST 6'h1F

`endif

// File: src/mdm_pkg.sv
// Types shared by the multiply/divide/accumulate unit
package mdm_pkg;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } mdm_bus_req_type;

    // Mode code is {div_select, mac_select, signed_select}
    typedef enum logic [2:0] {
        MDM_MUL_U = 3'h0,
        MDM_MUL_S = 3'h1,
        MDM_MAC_U = 3'h2,
        MDM_MAC_S = 3'h3,
        MDM_DIV_IRQ = 3'h4,
        MDM_DIV_QUIET = 3'h6
    } mdm_mode_type;

    typedef enum logic [1:0] {
        MDM_DV_IDLE = 2'h0,
        MDM_DV_RUN = 2'h1,
        MDM_DV_DONE = 2'h3
    } mdm_div_state_type;

    typedef struct packed {
        logic [31:0] quot;
        logic [31:0] rem;
    } mdm_div_res_type;

endpackage

// File: src/mdm_mac.sv
// Multiplier and accumulate adder with overflow and sign detection
`timescale 1ns/1ps
`default_nettype none
module mdm_mac (
    input wire logic [15:0] multiplicand,
    input wire logic [15:0] multiplier,
    input wire logic [31:0] acc,
    input wire logic sgn,
    output logic [31:0] product,
    output logic [31:0] sum,
    output logic ovf,
    output logic neg
);
    logic [31:0] prod_u;
    logic signed [31:0] prod_s;
    logic [32:0] sum_w;

    assign prod_u = {16'h0000, multiplier} * {16'h0000, multiplicand};
    assign prod_s = $signed(multiplier) * $signed(multiplicand);
    assign product = sgn ? prod_s : prod_u;
    assign sum_w = {1'b0, acc} + {1'b0, product};
    assign sum = sum_w[31:0];

    always_comb begin
        if (sgn) begin
            ovf = (acc[31] == product[31]) && (sum_w[31] != acc[31]);
            neg = sum_w[31];
        end else begin
            ovf = sum_w[32];
            neg = 1'b0;
        end
    end
endmodule // mdm_mac
`default_nettype wire

// File: src/mdm_divider.sv
// Restoring 32/32 unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "mdm_defines.svh"
module mdm_divider (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [31:0] divisor,
    output logic done,
    output mdm_pkg::mdm_div_res_type res
);
    mdm_pkg::mdm_div_state_type state_q;
    logic [31:0] rem_q, quot_q, dvs_q, dvd_q;
    logic [5:0] cnt_q;
    logic [32:0] shifted, diff;

    assign shifted = {rem_q, quot_q[31]};
    assign diff = shifted - {1'b0, dvs_q};
    assign done = (state_q == mdm_pkg::MDM_DV_DONE);
    assign res = '{quot: quot_q, rem: rem_q};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= mdm_pkg::MDM_DV_IDLE;
            cnt_q <= 6'h00;
        end else begin
            unique case (state_q)
                mdm_pkg::MDM_DV_IDLE: begin
                    if (start) begin
                        state_q <= mdm_pkg::MDM_DV_RUN;
                    end
                    cnt_q <= 6'h00;
                end
                mdm_pkg::MDM_DV_RUN: begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == `MDM_DIV_LAST) begin
                        state_q <= mdm_pkg::MDM_DV_DONE;
                    end
                end
                mdm_pkg::MDM_DV_DONE: begin
                    state_q <= mdm_pkg::MDM_DV_IDLE;
                end
                default: begin
                    state_q <= mdm_pkg::MDM_DV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rem_q <= 32'h0000_0000;
            quot_q <= 32'h0000_0000;
            dvs_q <= 32'h0000_0000;
            dvd_q <= 32'h0000_0000;
        end else if (state_q == mdm_pkg::MDM_DV_IDLE && start) begin
            rem_q <= 32'h0000_0000;
            quot_q <= dividend;
            dvd_q <= dividend;
            dvs_q <= divisor;
        end else if (state_q == mdm_pkg::MDM_DV_RUN) begin
            if (!diff[32]) begin
                rem_q <= diff[31:0];
                quot_q <= {quot_q[30:0], 1'b1};
            end else begin
                rem_q <= shifted[31:0];
                quot_q <= {quot_q[30:0], 1'b0};
            end
        end
    end

    property p_div_math;
        @(posedge ref_clk) disable iff (!rst_n)
        done && (dvs_q != 32'h0000_0000) |->
            ({32'h0000_0000, quot_q} * {32'h0000_0000, dvs_q} + {32'h0000_0000, rem_q}
             == {32'h0000_0000, dvd_q}) && (rem_q < dvs_q);
    endproperty
    a_div_math: assert property (p_div_math) else $error("quotient and remainder disagree");
endmodule // mdm_divider
`default_nettype wire

// File: src/mdm_top.sv
// Register-mapped multiply, multiply-accumulate and divide unit
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_defines.svh"
module mdm_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire mdm_pkg::mdm_bus_req_type bus,
    output logic [15:0] rd_data_q,
    output logic irq_q,
    output logic divide_done_irq_q
);
    logic [15:0] a_lo_q, a_hi_q, b_lo_q, b_hi_q, c_lo_q, c_hi_q;
    mdm_pkg::mdm_mode_type mode_q;
    logic ovf_q, neg_q, divide_go_q;
    logic pend_lo_q, pend_hi_q, mul_go_q;
    logic [2:0] ist_q, imask_q;

    logic [8:0] wr_sel, rd_sel;
    logic [2:0] new_mode;
    logic mode_ok, ctrl_wr, div_start, mac_hit;
    logic pend_lo_d, pend_hi_d, mul_go_d;
    logic [2:0] ist_ev, ist_clr;
    logic [15:0] rd_mux;
    logic [31:0] mac_prod, mac_sum;
    logic mac_ovf, mac_neg, div_done;
    mdm_pkg::mdm_div_res_type div_res;

    // Word address decode, shared by writes and reads
    function automatic logic [8:0] reg_dec(input logic [19:0] addr);
        case (addr)
            `MDM_OFS_A_LO: reg_dec = 9'h001;
            `MDM_OFS_A_HI: reg_dec = 9'h002;
            `MDM_OFS_B_LO: reg_dec = 9'h004;
            `MDM_OFS_B_HI: reg_dec = 9'h008;
            `MDM_OFS_C_LO: reg_dec = 9'h010;
            `MDM_OFS_C_HI: reg_dec = 9'h020;
            `MDM_OFS_CTRL: reg_dec = 9'h040;
            `MDM_OFS_IST: reg_dec = 9'h080;
            `MDM_OFS_IMASK: reg_dec = 9'h100;
            default: reg_dec = 9'h000;
        endcase
    endfunction

    function automatic logic legal_mode(input logic [2:0] m);
        legal_mode = (m == mdm_pkg::MDM_MUL_U) || (m == mdm_pkg::MDM_MUL_S) ||
                     (m == mdm_pkg::MDM_MAC_U) || (m == mdm_pkg::MDM_MAC_S) ||
                     (m == mdm_pkg::MDM_DIV_IRQ) || (m == mdm_pkg::MDM_DIV_QUIET);
    endfunction

    assign wr_sel = bus.wr ? reg_dec(bus.addr) : 9'h000;
    assign rd_sel = bus.rd ? reg_dec(bus.addr) : 9'h000;
    assign ctrl_wr = wr_sel[`MDM_SEL_CTRL];
    assign new_mode = {bus.wdata[`MDM_CTRL_DIV], bus.wdata[`MDM_CTRL_MAC], bus.wdata[`MDM_CTRL_SGN]};
    assign mode_ok = legal_mode(new_mode);
    // start only when a division mode is written
    assign div_start = ctrl_wr && mode_ok && new_mode[2] && bus.wdata[`MDM_CTRL_GO] && !divide_go_q;
    assign mac_hit = mul_go_q && mode_q[1] && !mode_q[2];

    // both halves written arms the multiply, except in the division modes
    assign pend_lo_d = pend_lo_q | wr_sel[`MDM_SEL_A_LO];
    assign pend_hi_d = pend_hi_q | wr_sel[`MDM_SEL_A_HI];
    assign mul_go_d = pend_lo_d && pend_hi_d && !mode_q[2];

    assign ist_ev = {mac_hit && mac_ovf, div_done, mul_go_q && !mode_q[2]};
    assign ist_clr = wr_sel[`MDM_SEL_IST] ? bus.wdata[2:0] : 3'h0;

    mdm_mac u_mac (
        .multiplicand(a_lo_q),
        .multiplier(a_hi_q),
        .acc({c_hi_q, c_lo_q}),
        .sgn(mode_q[0]),
        .product(mac_prod),
        .sum(mac_sum),
        .ovf(mac_ovf),
        .neg(mac_neg)
    );

    mdm_divider u_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(div_start),
        .dividend({a_hi_q, a_lo_q}),
        .divisor({b_hi_q, b_lo_q}),
        .done(div_done),
        .res(div_res)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            a_lo_q <= `MDM_DATA_RST;
            a_hi_q <= `MDM_DATA_RST;
        end else if (div_done) begin
            a_hi_q <= div_res.quot[31:16];
            a_lo_q <= div_res.quot[15:0];
        end else begin
            if (wr_sel[`MDM_SEL_A_LO]) begin
                a_lo_q <= bus.wdata;
            end
            if (wr_sel[`MDM_SEL_A_HI]) begin
                a_hi_q <= bus.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            b_lo_q <= `MDM_DATA_RST;
            b_hi_q <= `MDM_DATA_RST;
        end else if (mul_go_q && !mode_q[2]) begin
            b_hi_q <= mac_prod[31:16];
            b_lo_q <= mac_prod[15:0];
        end else begin
            if (wr_sel[`MDM_SEL_B_LO]) begin
                b_lo_q <= bus.wdata;
            end
            if (wr_sel[`MDM_SEL_B_HI]) begin
                b_hi_q <= bus.wdata;
            end
        end
    end

    // remainder or accumulated value into accum_c
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            c_lo_q <= `MDM_DATA_RST;
            c_hi_q <= `MDM_DATA_RST;
        end else if (div_done) begin
            c_hi_q <= div_res.rem[31:16];
            c_lo_q <= div_res.rem[15:0];
        end else if (mac_hit) begin
            c_hi_q <= mac_sum[31:16];
            c_lo_q <= mac_sum[15:0];
        end else begin
            if (wr_sel[`MDM_SEL_C_LO]) begin
                c_lo_q <= bus.wdata;
            end
            if (wr_sel[`MDM_SEL_C_HI]) begin
                c_hi_q <= bus.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_q <= mdm_pkg::MDM_MUL_U;
        end else if (ctrl_wr && mode_ok) begin
            mode_q <= mdm_pkg::mdm_mode_type'(new_mode);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divide_go_q <= 1'b0;
        end else if (div_start) begin
            divide_go_q <= 1'b1;
        end else if (div_done) begin
            divide_go_q <= 1'b0;
        end
    end

    // Overflow is sticky; a hardware set beats a software clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            if (mac_hit && mac_ovf) begin
                ovf_q <= 1'b1;
            end else if (ctrl_wr) begin
                ovf_q <= bus.wdata[`MDM_CTRL_OVF];
            end
            if (mac_hit) begin
                neg_q <= mac_neg;
            end
        end
    end

    // one clock from second operand write to product
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_lo_q <= 1'b0;
            pend_hi_q <= 1'b0;
            mul_go_q <= 1'b0;
        end else begin
            mul_go_q <= mul_go_d;
            pend_lo_q <= pend_lo_d && !mul_go_d && !mode_q[2];
            pend_hi_q <= pend_hi_d && !mul_go_d && !mode_q[2];
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ist_q <= `MDM_IRQ_RST;
            imask_q <= `MDM_IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            ist_q <= (ist_q & ~ist_clr) | ist_ev;
            if (wr_sel[`MDM_SEL_IMASK]) begin
                imask_q <= bus.wdata[2:0];
            end
            irq_q <= |(ist_q & imask_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divide_done_irq_q <= 1'b0;
        end else begin
            divide_done_irq_q <= div_done && (mode_q == mdm_pkg::MDM_DIV_IRQ);
        end
    end

    always_comb begin
        rd_mux = 16'h0000;
        if (rd_sel[`MDM_SEL_A_LO]) rd_mux = a_lo_q;
        if (rd_sel[`MDM_SEL_A_HI]) rd_mux = a_hi_q;
        if (rd_sel[`MDM_SEL_B_LO]) rd_mux = b_lo_q;
        if (rd_sel[`MDM_SEL_B_HI]) rd_mux = b_hi_q;
        if (rd_sel[`MDM_SEL_C_LO]) rd_mux = c_lo_q;
        if (rd_sel[`MDM_SEL_C_HI]) rd_mux = c_hi_q;
        if (rd_sel[`MDM_SEL_CTRL]) rd_mux = {8'h00, mode_q[2], mode_q[1], 2'h0, mode_q[0], ovf_q, neg_q, divide_go_q};
        if (rd_sel[`MDM_SEL_IST]) rd_mux = {13'h0000, ist_q};
        if (rd_sel[`MDM_SEL_IMASK]) rd_mux = {13'h0000, imask_q};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= rd_mux;
        end
    end

    property p_mul_unsigned;
        @(posedge ref_clk) disable iff (!rst_n)
        mul_go_q && !mode_q[2] && !mode_q[0] |=>
            {b_hi_q, b_lo_q} == {16'h0000, $past(a_hi_q)} * {16'h0000, $past(a_lo_q)};
    endproperty
    a_mul_unsigned: assert property (p_mul_unsigned) else $error("unsigned product wrong");

    property p_mul_signed;
        @(posedge ref_clk) disable iff (!rst_n)
        mul_go_q && !mode_q[2] && mode_q[0] |=>
            $signed({b_hi_q, b_lo_q}) == $signed($past(a_hi_q)) * $signed($past(a_lo_q));
    endproperty
    a_mul_signed: assert property (p_mul_signed) else $error("signed product wrong");

    property p_mac_sum;
        @(posedge ref_clk) disable iff (!rst_n)
        mac_hit |=> {c_hi_q, c_lo_q} == $past({c_hi_q, c_lo_q}) + {b_hi_q, b_lo_q};
    endproperty
    a_mac_sum: assert property (p_mac_sum) else $error("accumulated value wrong");

    property p_mul_latency;
        @(posedge ref_clk) disable iff (!rst_n)
        bus.wr && (bus.addr == `MDM_OFS_A_HI) && pend_lo_q && !mode_q[2] |=> mul_go_q ##1 !mul_go_q;
    endproperty
    a_mul_latency: assert property (p_mul_latency) else $error("multiply not started");

    property p_reset_clear;
        @(posedge ref_clk)
        !rst_n |=> (a_lo_q == 16'h0000) && (a_hi_q == 16'h0000) && (b_lo_q == 16'h0000) &&
                   (b_hi_q == 16'h0000) && (c_lo_q == 16'h0000) && (c_hi_q == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("data not cleared by reset");

    sequence s_div_busy;
        divide_go_q [*8];
    endsequence

    property p_div_duration;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(divide_go_q) |-> s_div_busy ##25 divide_go_q ##1 !divide_go_q;
    endproperty
    a_div_duration: assert property (p_div_duration) else $error("division length wrong");

    property p_div_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(divide_go_q) |-> (divide_done_irq_q == ($past(mode_q) == mdm_pkg::MDM_DIV_IRQ)) ##1 !divide_done_irq_q;
    endproperty
    a_div_irq: assert property (p_div_irq) else $error("completion pulse wrong");

    property p_div_rem;
        @(posedge ref_clk) disable iff (!rst_n)
        div_done |=> ({c_hi_q, c_lo_q} == $past(div_res.rem)) && ({a_hi_q, a_lo_q} == $past(div_res.quot));
    endproperty
    a_div_rem: assert property (p_div_rem) else $error("division results misplaced");

    property p_read_back;
        @(posedge ref_clk) disable iff (!rst_n)
        bus.rd && (bus.addr == `MDM_OFS_C_HI) |=> rd_data_q == $past(c_hi_q);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong");

    property p_mode_refused;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_wr && !legal_mode(new_mode) |=> mode_q == $past(mode_q);
    endproperty
    a_mode_refused: assert property (p_mode_refused) else $error("prohibited mode taken");
endmodule // mdm_top
`default_nettype wire

// File: dv/mdm_top_test.sv
// Self-checking testbench of the multiply, accumulate and divide unit
`timescale 1ns/1ps
`default_nettype none
`include "mdm_defines.svh"
module mdm_top_test;
    logic ref_clk;
    logic rst_n;
    mdm_pkg::mdm_bus_req_type bus;
    logic [15:0] rd_data_q;
    logic irq_q;
    logic divide_done_irq_q;
    int cycles;
    int mismatches;
    int checks_done;
    int pulses;
    logic [15:0] rv;
    logic [31:0] pv;

    mdm_top dut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(bus),
        .rd_data_q(rd_data_q),
        .irq_q(irq_q),
        .divide_done_irq_q(divide_done_irq_q)
    );

    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (divide_done_irq_q === 1'b1) begin
            pulses++;
        end
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    // Read data is taken in the single cycle after the strobe
    task automatic rd(input logic [19:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 d = rd_data_q;
    endtask

    task automatic pair(input logic [19:0] ah, input logic [19:0] al, output logic [31:0] v);
        logic [15:0] h;
        logic [15:0] l;
        rd(ah, h);
        rd(al, l);
        v = {h, l};
    endtask

    task automatic mul(input logic [15:0] ctrl, input logic [15:0] lo, input logic [15:0] hi);
        wr(`MDM_OFS_CTRL, ctrl);
        wr(`MDM_OFS_A_LO, lo);
        wr(`MDM_OFS_A_HI, hi);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic t_regs;
        logic [19:0] ofs [6];
        ofs = '{`MDM_OFS_A_LO, `MDM_OFS_A_HI, `MDM_OFS_B_LO, `MDM_OFS_B_HI, `MDM_OFS_C_LO, `MDM_OFS_C_HI};
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], rv);
            chk(32'(rv), 32'h0); // cleared at reset
        end
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 16'h0A5C | 16'(i << 12));
        end
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], rv);
            chk(32'(rv), 32'h0A5C | 32'(i << 12)); // half access
        end
    endtask

    task automatic t_mul;
        mul(16'h0000, 16'hFFFF, 16'hFFFF);
        pair(`MDM_OFS_B_HI, `MDM_OFS_B_LO, pv);
        chk(pv, 32'hFFFE0001); // product in result_b
        mul(16'h0008, 16'h7FFF, 16'hFFFE);
        pair(`MDM_OFS_B_HI, `MDM_OFS_B_LO, pv);
        chk(pv, 32'hFFFF0002); // signed product
        pair(`MDM_OFS_C_HI, `MDM_OFS_C_LO, pv);
        chk(pv, 32'h5A5C4A5C); // accum_c untouched
        rd(`MDM_OFS_IST, rv);
        chk(32'(rv[`MDM_IST_MUL]), 32'h1); // product done
        chk(32'(irq_q), 32'h0); // masked event stays quiet
    endtask

    task automatic t_mac;
        wr(`MDM_OFS_C_HI, 16'h0001);
        wr(`MDM_OFS_C_LO, 16'h0000);
        mul(16'h0040, 16'h0003, 16'h0004);
        mul(16'h0040, 16'h0003, 16'h0004);
        pair(`MDM_OFS_B_HI, `MDM_OFS_B_LO, pv);
        chk(pv, 32'h0000000C); // product kept
        pair(`MDM_OFS_C_HI, `MDM_OFS_C_LO, pv);
        chk(pv, 32'h00010018); // accumulated twice
        wr(`MDM_OFS_C_HI, 16'hFFFF);
        wr(`MDM_OFS_C_LO, 16'h0000);
        mul(16'h0040, 16'hFFFF, 16'hFFFF);
        rd(`MDM_OFS_CTRL, rv);
        chk(32'(rv), 32'h0044); // unsigned overflow flagged
        rd(`MDM_OFS_IST, rv);
        chk(32'(rv[`MDM_IST_OVF]), 32'h1); // overflow event
        wr(`MDM_OFS_C_HI, 16'h0000);
        wr(`MDM_OFS_C_LO, 16'h0000);
        mul(16'h0048, 16'hFFFF, 16'h0005);
        mul(16'h0048, 16'hFFFF, 16'h0005);
        pair(`MDM_OFS_B_HI, `MDM_OFS_B_LO, pv);
        chk(pv, 32'hFFFFFFFB); // signed product
        pair(`MDM_OFS_C_HI, `MDM_OFS_C_LO, pv);
        chk(pv, 32'hFFFFFFF6); // signed sum
        rd(`MDM_OFS_CTRL, rv);
        chk(32'(rv), 32'h004A); // negative sum flagged
    endtask

    task automatic t_div;
        int n;
        wr(`MDM_OFS_A_HI, 16'h0001);
        wr(`MDM_OFS_A_LO, 16'h0005);
        wr(`MDM_OFS_B_HI, 16'h0000);
        wr(`MDM_OFS_B_LO, 16'h0010);
        wr(`MDM_OFS_CTRL, 16'h0081);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (divide_done_irq_q !== 1'b1 && n < 100);
        chk(32'(n), 32'(`MDM_DIV_LAST) + 32'd2); // fixed duration
        @(posedge ref_clk);
        #1 chk(32'(divide_done_irq_q), 32'h0); // one clock pulse
        pair(`MDM_OFS_A_HI, `MDM_OFS_A_LO, pv);
        chk(pv, 32'h00001000); // quotient in operand_a
        pair(`MDM_OFS_C_HI, `MDM_OFS_C_LO, pv);
        chk(pv, 32'h00000005); // remainder in accum_c
        // Sign flag still shows the last negative accumulated value
        rd(`MDM_OFS_CTRL, rv);
        chk(32'(rv), 32'h0082); // go clears itself
        rd(`MDM_OFS_IST, rv);
        chk(32'(rv[`MDM_IST_DIV]), 32'h1); // division done event
    endtask

    task automatic t_quiet;
        int p;
        int n;
        p = pulses;
        wr(`MDM_OFS_A_HI, 16'hFFFF);
        wr(`MDM_OFS_A_LO, 16'hFFFF);
        wr(`MDM_OFS_B_HI, 16'h0001);
        wr(`MDM_OFS_B_LO, 16'h0000);
        wr(`MDM_OFS_CTRL, 16'h00C1);
        wr(`MDM_OFS_CTRL, 16'h00C0);
        rd(`MDM_OFS_CTRL, rv);
        chk(32'(rv), 32'h00C3); // go not cleared by software
        n = 0;
        do begin
            rd(`MDM_OFS_CTRL, rv);
            n++;
        end while (rv[`MDM_CTRL_GO] !== 1'b0 && n < 40);
        chk(32'(rv), 32'h00C2); // finished
        chk(32'(pulses - p), 32'h0); // quiet division mode
        pair(`MDM_OFS_A_HI, `MDM_OFS_A_LO, pv);
        chk(pv, 32'h0000FFFF); // quotient in operand_a
        pair(`MDM_OFS_C_HI, `MDM_OFS_C_LO, pv);
        chk(pv, 32'h0000FFFF); // remainder
    endtask

    task automatic t_modes;
        logic [15:0] bad [2];
        bad = '{16'h0088, 16'h00C8};
        for (int i = 0; i < 2; i++) begin
            wr(`MDM_OFS_CTRL, bad[i]);
            rd(`MDM_OFS_CTRL, rv);
            chk(32'(rv), 32'h00C2); // prohibited code ignored
        end
    endtask

    task automatic t_irq;
        wr(`MDM_OFS_IMASK, 16'h0001);
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(irq_q), 32'h1); // unmasked product event
        wr(`MDM_OFS_IST, 16'h0007);
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(irq_q), 32'h0); // event cleared
        rd(`MDM_OFS_IST, rv);
        chk(32'(rv), 32'h0); // status cleared
        rd(20'h00010, rv);
        chk(32'(rv), 32'h0); // unmapped read
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        bus = '0;
        cycles = 0;
        mismatches = 0;
        checks_done = 0;
        pulses = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_mul();
        t_mac();
        t_div();
        t_quiet();
        t_modes();
        t_irq();
        end_sim();
    end
endmodule // mdm_top_test
`default_nettype wire
